// *** rtl/ldo_ctrl_map.svh ***
// Contract
// R1 - Dual-range 5-bit code: 0-15 give 0.75-1.5 V by 50 mV, 16-31 1.8-3.3 V by 100 mV.
// R2 - Dual-range low codes use the low-range pass device, high codes the high-range one.
// R3 - Single-range 4-bit code: 0 gives 1.80 V, up 100 mV steps to 3.30 V.
// R4 - Dual-range enable: off if bit clear; Run on; Standby needs standby bit; Sleep sleep bit.
// R5 - Single-range regulator uses the same enable decoding.
// R6 - Low-power only in Standby or Sleep with its low-power bit set; ignored in Run.
// R7 - A disabled regulator has its discharge pull-down on.
// R8 - Single-range pull-down also on while processor reset output is low.
// R9 - Short-circuit detection is debounced before shutdown or interrupt.
// R10 - With protection enabled, a fault clears the enable bit and raises the fault flag.
// R11 - With protection disabled, an overloaded regulator stays enabled in current limit.
// R12 - The fault flag is raised on every overload whatever the protection bit; none is raised while a dual-range regulator is a load switch.
// R13 - Each fault flag has its own mask; a set mask hides it from the processor.
// R14 - Protection enable is clear after reset.
// R15 - Dual-range load-switch bit drives the pass device fully on.
// R16 - Current limit is inactive while a dual-range regulator is a load switch.
// R17 - Soft-start ramp runs whenever a load switch turns on.
// R18 - Reference ramps gradually at regulator power-up.
// R19 - Backup domain fed from system supply above upper threshold, coin cell below lower.
// R20 - Fault flags stay latched until software clears them.
// R21 - Overcurrent inputs are synchronised; debounce time is a build parameter.
// R22 - Effective enable is recomputed from power state and configuration bits.
`ifndef LDO_CTRL_MAP_SVH
`define LDO_CTRL_MAP_SVH
`define REG_NUM 3
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_MODE 4'h1
`define OFS_VOLT0 4'h2
`define OFS_VOLT1 4'h3
`define OFS_VOLT2 4'h4
`define OFS_FAULT 4'h5
`define OFS_MASK 4'h6
`define OFS_STATUS 4'h7
`define CTRL_PROT_BIT 3
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define MASK_RESET 8'h00
`define VOLT_RESET 8'h00
`define DEBOUNCE_TIME_US 100
`define CLK_MHZ 100
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_US * `CLK_MHZ)
`define RAMP_STEP_CYCLES 16
`define RAMP_MAX 8'hFF
`endif

// *** rtl/ldo_ctrl_pkg.sv ***
`include "ldo_ctrl_map.svh"
package ldo_ctrl_pkg;
    typedef enum logic [1:0]
    {
        PS_RUN = 2'b00,
        PS_STANDBY = 2'b01,
        PS_SLEEP = 2'b10
    } power_state_type;

    typedef enum logic [1:0]
    {
        RAMP_OFF = 2'b00,
        RAMP_UP = 2'b01,
        RAMP_DONE = 2'b10
    } ramp_state_type;

    typedef struct packed
    {
        logic on;
        logic low_power;
        logic high_range;
        logic full_on;
        logic limit_on;
        logic discharge;
        logic [8:0] millivolt_div10;
        logic [7:0] ramp;
    } reg_drive_type;

    typedef struct packed
    {
        logic [`ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
endpackage

// *** rtl/ldo_ctrl.sv ***
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "ldo_ctrl_map.svh"
module ldo_ctrl
#(
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
)
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire ldo_ctrl_pkg::bus_req_type bus_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] power_state_i,
    input wire logic [`REG_NUM-1:0] overcurrent_i,
    input wire logic [1:0] otp_dual_range_switch_select_i,
    input wire logic processor_reset_out_n_i,
    input wire logic above_upper_threshold_i,
    input wire logic below_lower_threshold_i,
    output ldo_ctrl_pkg::reg_drive_type [`REG_NUM-1:0] drive_o,
    output logic [`REG_NUM-1:0] fault_irq_o,
    output logic backup_from_system_o
);
    // ------------------------------------------------------------
    // Registers. Index 0 and 2 are dual-range, index 1 single-range.
    // ------------------------------------------------------------
    // CTRL: [2:0] enable bits, [3] protection enable.
    // MODE: [2:0] standby enable, [5:3] sleep enable; VOLT: [5] low-power, code below.
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] volt_reg [`REG_NUM];
    logic [`REG_NUM-1:0] fault_reg;
    logic [`REG_NUM-1:0] mask_reg;
    logic [`REG_NUM-1:0] sync1_reg;
    logic [`REG_NUM-1:0] sync2_reg;
    logic [`REG_NUM-1:0] deb_reg;
    logic [`REG_NUM-1:0] deb_rise;
    logic [`REG_NUM-1:0] eff_en;
    logic [`REG_NUM-1:0] lp_next;
    logic [`REG_NUM-1:0] lp_bit;
    logic [`REG_NUM-1:0] limit_ok;
    logic [`REG_NUM-1:0] prev_deb_reg;
    logic rst_low_sync1_reg;
    logic rst_low_sync2_reg;
    logic above_sync1_reg;
    logic above_sync2_reg;
    logic below_sync1_reg;
    logic below_sync2_reg;
    logic [1:0] ps_sync1_reg;
    logic [1:0] ps_sync2_reg;
    ldo_ctrl_pkg::power_state_type ps;

    assign ps = ldo_ctrl_pkg::power_state_type'(ps_sync2_reg);

    // ------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------
    // R21 two-stage sync
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            rst_low_sync1_reg <= 1'b1;
            rst_low_sync2_reg <= 1'b1;
            above_sync1_reg <= 1'b0;
            above_sync2_reg <= 1'b0;
            below_sync1_reg <= 1'b0;
            below_sync2_reg <= 1'b0;
            ps_sync1_reg <= 2'b00;
            ps_sync2_reg <= 2'b00;
        end
        else
        begin
            sync1_reg <= overcurrent_i;
            sync2_reg <= sync1_reg;
            rst_low_sync1_reg <= ~processor_reset_out_n_i;
            rst_low_sync2_reg <= rst_low_sync1_reg;
            above_sync1_reg <= above_upper_threshold_i;
            above_sync2_reg <= above_sync1_reg;
            below_sync1_reg <= below_lower_threshold_i;
            below_sync2_reg <= below_sync1_reg;
            ps_sync1_reg <= power_state_i;
            ps_sync2_reg <= ps_sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // Enable, low-power and range decode per regulator.
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `REG_NUM; g++)
        begin : g_reg
            logic [15:0] cnt_reg;
            ldo_ctrl_pkg::ramp_state_type rst_reg;
            logic [7:0] ramp_reg;
            logic [4:0] code;
            logic is_dual;
            logic ls;
            logic oc_seen;

            assign is_dual = (g != 1);
            assign ls = is_dual && otp_dual_range_switch_select_i[g / 2];
            assign code = is_dual ? volt_reg[g][4:0] : {1'b1, volt_reg[g][3:0]};
            assign lp_bit[g] = volt_reg[g][5];

            // R4 R5 R22 enable decode
            always_comb
            begin
                case (ps)
                    ldo_ctrl_pkg::PS_RUN: eff_en[g] = ctrl_reg[g];
                    ldo_ctrl_pkg::PS_STANDBY: eff_en[g] = ctrl_reg[g] & mode_reg[g];
                    ldo_ctrl_pkg::PS_SLEEP: eff_en[g] = ctrl_reg[g] & mode_reg[g + 3];
                    default: eff_en[g] = 1'b0;
                endcase
            end

            // R6 low-power only off Run
            assign lp_next[g] = eff_en[g] && lp_bit[g] && (ps != ldo_ctrl_pkg::PS_RUN);
            // R16 no limit as switch
            assign limit_ok[g] = ~ls;
            assign oc_seen = sync2_reg[g] & limit_ok[g];

            // R9 fault debounce counter
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    cnt_reg <= 16'h0000;
                    deb_reg[g] <= 1'b0;
                end
                else if (oc_seen != deb_reg[g])
                begin
                    if (cnt_reg >= 16'(DEBOUNCE_CYCLES - 1))
                    begin
                        cnt_reg <= 16'h0000;
                        deb_reg[g] <= oc_seen;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                else
                begin
                    cnt_reg <= 16'h0000;
                end
            end

            // R17 R18 soft-start ramp
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    rst_reg <= ldo_ctrl_pkg::RAMP_OFF;
                    ramp_reg <= 8'h00;
                end
                else
                begin
                    case (rst_reg)
                        ldo_ctrl_pkg::RAMP_OFF:
                        begin
                            ramp_reg <= 8'h00;
                            if (eff_en[g])
                                rst_reg <= ldo_ctrl_pkg::RAMP_UP;
                        end
                        ldo_ctrl_pkg::RAMP_UP:
                        begin
                            if (!eff_en[g])
                                rst_reg <= ldo_ctrl_pkg::RAMP_OFF;
                            else if (ramp_reg == `RAMP_MAX)
                                rst_reg <= ldo_ctrl_pkg::RAMP_DONE;
                            else
                                ramp_reg <= ramp_reg + 8'h01;
                        end
                        ldo_ctrl_pkg::RAMP_DONE:
                        begin
                            if (!eff_en[g])
                                rst_reg <= ldo_ctrl_pkg::RAMP_OFF;
                        end
                        default: rst_reg <= ldo_ctrl_pkg::RAMP_OFF;
                    endcase
                end
            end

            // R1 R2 R3 R7 R8 R15 output drive
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    drive_o[g] <= '{on: 1'b0, low_power: 1'b0, high_range: 1'b0, full_on: 1'b0,
                                    limit_on: 1'b0, discharge: 1'b1, millivolt_div10: 9'h000,
                                    ramp: 8'h00};
                end
                else
                begin
                    drive_o[g].on <= eff_en[g];
                    drive_o[g].low_power <= lp_next[g];
                    drive_o[g].high_range <= code[4];
                    drive_o[g].full_on <= ls & eff_en[g];
                    drive_o[g].limit_on <= limit_ok[g] & eff_en[g];
                    drive_o[g].discharge <= ~eff_en[g] | (~is_dual & rst_low_sync2_reg);
                    drive_o[g].millivolt_div10 <= code[4] ? 9'(9'h0B4 + 9'h00A * code[3:0])
                                                          : 9'(9'h04B + 9'h005 * code[3:0]);
                    drive_o[g].ramp <= ramp_reg;
                end
            end
        end
    endgenerate

    assign deb_rise = deb_reg & ~prev_deb_reg;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prev_deb_reg <= '0;
        else
            prev_deb_reg <= deb_reg;
    end

    // ------------------------------------------------------------
    // Register bus writes and hardware updates.
    // ------------------------------------------------------------
    // R14 protection clear at reset
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg <= `CTRL_RESET;
        end
        else
        begin
            if (bus_i.wr && bus_i.addr == `OFS_CTRL)
                ctrl_reg <= bus_i.wdata;
            // R10 R11 auto-disable only when protected
            if (ctrl_reg[`CTRL_PROT_BIT])
                ctrl_reg[`REG_NUM-1:0] <= (bus_i.wr && bus_i.addr == `OFS_CTRL ?
                    bus_i.wdata[`REG_NUM-1:0] : ctrl_reg[`REG_NUM-1:0]) & ~deb_rise;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_reg <= `MODE_RESET;
            mask_reg <= '0;
            for (int i = 0; i < `REG_NUM; i++)
                volt_reg[i] <= `VOLT_RESET;
        end
        else if (bus_i.wr)
        begin
            case (bus_i.addr)
                `OFS_MODE: mode_reg <= bus_i.wdata;
                `OFS_MASK: mask_reg <= bus_i.wdata[`REG_NUM-1:0];
                `OFS_VOLT0: volt_reg[0] <= bus_i.wdata;
                `OFS_VOLT1: volt_reg[1] <= bus_i.wdata;
                `OFS_VOLT2: volt_reg[2] <= bus_i.wdata;
                default: mode_reg <= mode_reg;
            endcase
        end
    end

    // R12 R20 sticky fault flags, set wins
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fault_reg <= '0;
        else if (bus_i.wr && bus_i.addr == `OFS_FAULT)
            fault_reg <= (fault_reg & ~bus_i.wdata[`REG_NUM-1:0]) | deb_rise;
        else
            fault_reg <= fault_reg | deb_rise;
    end

    // ------------------------------------------------------------
    // Read data, interrupt lines and backup supply selection.
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (bus_i.rd)
        begin
            case (bus_i.addr)
                `OFS_CTRL: rdata_o <= ctrl_reg;
                `OFS_MODE: rdata_o <= mode_reg;
                `OFS_VOLT0: rdata_o <= volt_reg[0];
                `OFS_VOLT1: rdata_o <= volt_reg[1];
                `OFS_VOLT2: rdata_o <= volt_reg[2];
                `OFS_FAULT: rdata_o <= {5'h00, fault_reg};
                `OFS_MASK: rdata_o <= {5'h00, mask_reg};
                `OFS_STATUS: rdata_o <= {2'h0, deb_reg, eff_en};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // R13 masked fault output
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            fault_irq_o <= '0;
        else
            fault_irq_o <= fault_reg & ~mask_reg;
    end

    // R19 hysteresis source select
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            backup_from_system_o <= 1'b0;
        else if (above_sync2_reg)
            backup_from_system_o <= 1'b1;
        else if (below_sync2_reg)
            backup_from_system_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_disabled_discharge: assert property (!eff_en[0] |=> drive_o[0].discharge) // R7
        else $error("Disabled regulator without discharge.");
    chk_run_no_lowpower: assert property (ps == ldo_ctrl_pkg::PS_RUN |=> !drive_o[1].low_power) // R6
        else $error("Low power asserted in run.");
    chk_standby_enable: assert property (ps == ldo_ctrl_pkg::PS_STANDBY && ctrl_reg[2] && !mode_reg[2]
        |=> !drive_o[2].on) // R4
        else $error("Standby enable ignored.");
    chk_single_enable: assert property (ps == ldo_ctrl_pkg::PS_SLEEP && !mode_reg[4] |=> !drive_o[1].on) // R5
        else $error("Single regulator sleep enable ignored.");
    chk_reset_discharge: assert property (rst_low_sync2_reg |=> drive_o[1].discharge) // R8
        else $error("Single discharge missing during processor reset.");
    chk_fault_sticky: assert property (deb_rise[0] |=> fault_reg[0]) // R12
        else $error("Fault flag not raised.");
    chk_fault_hold: assert property (fault_reg[1] && !(bus_i.wr && bus_i.addr == `OFS_FAULT)
        |=> fault_reg[1]) // R20
        else $error("Fault flag dropped without clear.");
    chk_prot_disable: assert property (ctrl_reg[`CTRL_PROT_BIT] && deb_rise[2] |=> !ctrl_reg[2]) // R10
        else $error("Protected regulator not disabled.");
    chk_unprot_keep: assert property (!ctrl_reg[`CTRL_PROT_BIT] && ctrl_reg[0] && !bus_i.wr
        |=> ctrl_reg[0]) // R11
        else $error("Unprotected regulator disabled.");
    chk_mask_irq: assert property (mask_reg[0] |=> !fault_irq_o[0]) // R13
        else $error("Masked fault signalled.");
    chk_hysteresis: assert property (above_sync2_reg |=> backup_from_system_o) // R19
        else $error("Backup source not switched to system supply.");
    chk_switch_no_limit: assert property (otp_dual_range_switch_select_i[0] |=> !drive_o[0].limit_on) // R16
        else $error("Current limit active on load switch.");
    chk_switch_full_on: assert property (otp_dual_range_switch_select_i[0] && eff_en[0] |=> drive_o[0].full_on) // R15
        else $error("Load switch not fully on.");
    chk_range_select: assert property (volt_reg[0][4] |=> drive_o[0].high_range) // R2
        else $error("High range pass device not selected.");
    chk_lowpower_apply: assert property (ps != ldo_ctrl_pkg::PS_RUN && eff_en[2] && lp_bit[2]
        |=> drive_o[2].low_power) // R6
        else $error("Low power not applied off run.");

    cov_fault_shutdown: cover property (ctrl_reg[`CTRL_PROT_BIT] && deb_rise[0]);
    cov_standby_lowpower: cover property (drive_o[0].low_power);
    cov_coin_cell: cover property ($fell(backup_from_system_o));
    cov_load_switch: cover property (drive_o[0].full_on);
    cov_processor_reset: cover property (rst_low_sync2_reg && drive_o[1].discharge);
endmodule

// *** test/ldo_analog_model.sv ***
`timescale 1ns/100ps
module ldo_analog_model
#(
    parameter int UPPER_MV = 3100,
    parameter int LOWER_MV = 2900
)
(
    input wire ldo_ctrl_pkg::reg_drive_type [2:0] drive_i,
    input wire logic [2:0] short_i,
    input wire logic [12:0] supply_mv_i,
    output logic [2:0] overcurrent_o,
    output logic above_upper_threshold_o,
    output logic below_lower_threshold_o
);
    // Overload current only flows while the pass device conducts into the short.
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            overcurrent_o[i] = short_i[i] & drive_i[i].on;
        end
    end

    // Two comparators with a gap between their trip points.
    assign above_upper_threshold_o = (supply_mv_i > 13'(UPPER_MV));
    assign below_lower_threshold_o = (supply_mv_i < 13'(LOWER_MV));
endmodule

// *** test/tb_ldo_ctrl.sv ***
`timescale 1ns/100ps
module tb_ldo_ctrl;
    logic sys_clk;
    logic nrst;
    ldo_ctrl_pkg::bus_req_type bus;
    logic [7:0] rdata;
    logic [1:0] pstate;
    logic [2:0] oc;
    logic [1:0] otp;
    logic rst_out_n;
    logic above;
    logic below;
    ldo_ctrl_pkg::reg_drive_type [2:0] drive;
    logic [2:0] irq;
    logic backup;
    logic [2:0] short;
    logic [12:0] supply_mv;
    logic [7:0] rv;
    int failures;
    int num_checks;
    int cycles;

    // ------------------------------------------------------------
    // Clock, design and analog side
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ldo_ctrl #(.DEBOUNCE_CYCLES(4)) ldo_ctrl_inst (.sys_clk_i(sys_clk), .nrst_i(nrst), .bus_i(bus),
        .rdata_o(rdata), .power_state_i(pstate), .overcurrent_i(oc), .otp_dual_range_switch_select_i(otp),
        .processor_reset_out_n_i(rst_out_n), .above_upper_threshold_i(above), .below_lower_threshold_i(below),
        .drive_o(drive), .fault_irq_o(irq), .backup_from_system_o(backup));

    ldo_analog_model ldo_analog_model_inst (.drive_i(drive), .short_i(short), .supply_mv_i(supply_mv),
        .overcurrent_o(oc), .above_upper_threshold_o(above), .below_lower_threshold_o(below));

    // ------------------------------------------------------------
    // Bus, wait and check tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] g, input logic [8:0] e, input string m);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic set_short(input logic [2:0] s);
        @(posedge sys_clk);
        short <= s;
    endtask

    task automatic wait_irq(input int i, input logic e);
        int n;
        n = 0;
        while (irq[i] !== e && n < 40)
        begin
            cyc(1);
            n++;
        end
        chk(irq[i], e, "fault irq");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        cyc(1);
        for (int r = 0; r < 3; r++)
        begin
            chk({drive[r].on, drive[r].discharge}, 9'h001, "reset drive");
        end
        chk({irq, backup}, 9'h000, "reset irq");
        rd(4'h0, rv);
        chk(rv, 9'h000, "protect after reset");
        wr(4'h1, 8'h2A);
        rd(4'h1, rv);
        chk(rv, 9'h02A, "mode readback");
        wr(4'hF, 8'hFF);
        for (int a = 8; a < 16; a++)
        begin
            rd(4'(a), rv);
            chk(rv, 9'h000, "unmapped read");
        end
        rd(4'h1, rv);
        chk(rv, 9'h02A, "unmapped write");
    endtask

    task automatic t_volt();
        int e;
        wr(4'h0, 8'h07);
        for (int c = 0; c < 32; c++)
        begin
            e = (c < 16) ? 75 + 5 * c : 180 + 10 * (c - 16);
            wr(4'h2, 8'(c));
            wr(4'h3, 8'(c % 16));
            wr(4'h4, 8'(c));
            cyc(3);
            chk(drive[0].millivolt_div10, 9'(e), "dual code");
            chk(drive[2].millivolt_div10, 9'(e), "dual code");
            chk(drive[0].high_range, 9'(c / 16), "range");
            chk(drive[1].millivolt_div10, 9'(180 + 10 * (c % 16)), "single code");
        end
    endtask

    task automatic t_enable();
        logic on;
        for (int p = 0; p < 3; p++)
        begin
            @(posedge sys_clk);
            pstate <= 2'(p);
            for (int k = 0; k < 16; k++)
            begin
                wr(4'h0, k[0] ? 8'h07 : 8'h00);
                wr(4'h1, {2'b00, {3{k[2]}}, {3{k[1]}}});
                for (int r = 0; r < 3; r++)
                begin
                    wr(4'(2 + r), {2'b00, k[3], 5'h10});
                end
                cyc(4);
                on = k[0] && (p == 0 || (p == 1 && k[1]) || (p == 2 && k[2]));
                for (int r = 0; r < 3; r++)
                begin
                    chk(drive[r].on, on, "enable");
                    chk(drive[r].discharge, !on, "discharge");
                    if (on)
                    begin
                        chk(drive[r].low_power, p != 0 && k[3], "low power");
                    end
                end
                rd(4'h7, rv);
                chk(rv[2:0], {3{on}}, "status enable");
            end
        end
        @(posedge sys_clk);
        pstate <= 2'b00;
        wr(4'h0, 8'h07);
        @(posedge sys_clk);
        rst_out_n <= 1'b0;
        cyc(5);
        chk({drive[1].discharge, drive[0].discharge}, 9'h002, "reset pull-down");
        @(posedge sys_clk);
        rst_out_n <= 1'b1;
        cyc(5);
        chk(drive[1].discharge, 9'h000, "reset pull-down off");
    endtask

    task automatic t_fault();
        wr(4'h0, 8'h0F);
        set_short(3'b010);
        wait_irq(1, 1'b1);
        chk({drive[1].on, drive[1].discharge}, 9'h001, "shut down");
        rd(4'h0, rv);
        chk(rv, 9'h00D, "enable cleared");
        set_short(3'b000);
        cyc(10);
        chk(irq[1], 9'h001, "latched");
        wr(4'h5, 8'h02);
        cyc(3);
        chk(irq[1], 9'h000, "cleared");
        wr(4'h0, 8'h07);
        set_short(3'b001);
        wait_irq(0, 1'b1);
        rd(4'h0, rv);
        chk({drive[0].on, rv}, 9'h107, "kept on");
        wr(4'h6, 8'h04);
        set_short(3'b101);
        cyc(30);
        chk(irq[2], 9'h000, "masked");
        rd(4'h5, rv);
        chk(rv, 9'h005, "flags");
        wr(4'h6, 8'h00);
        wait_irq(2, 1'b1);
        set_short(3'b000);
        wr(4'h5, 8'h07);
        cyc(12);
        set_short(3'b001);
        repeat (2) @(posedge sys_clk);
        short <= 3'b000;
        cyc(30);
        rd(4'h5, rv);
        chk({irq, rv}, 9'h000, "short glitch");
    endtask

    task automatic t_switch();
        wr(4'h0, 8'h00);
        @(posedge sys_clk);
        otp <= 2'b11;
        cyc(5);
        wr(4'h0, 8'h07);
        cyc(4);
        chk(drive[0].ramp < 8'hFF, 9'h001, "switch ramp start");
        chk(drive[1].ramp < 8'hFF, 9'h001, "ramp start");
        cyc(5000);
        chk({drive[0].ramp, drive[1].ramp == 8'hFF}, 9'h1FF, "ramp end");
        chk({drive[0].full_on, drive[2].full_on, drive[1].full_on}, 9'h006, "full on");
        chk({drive[0].limit_on, drive[1].limit_on}, 9'h001, "limit");
        set_short(3'b001);
        cyc(30);
        chk(irq[0], 9'h000, "switch overload");
        set_short(3'b000);
        @(posedge sys_clk);
        otp <= 2'b00;
    endtask

    task automatic t_backup();
        logic [12:0] mv[4] = '{13'h0CE4, 13'h0BB8, 13'h0AF0, 13'h0BB8};
        logic [3:0] ex = 4'b0011;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            supply_mv <= mv[i];
            cyc(6);
            chk(backup, ex[i], "backup source");
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        nrst = 1'b0;
        bus = '0;
        pstate = 2'b00;
        otp = 2'b00;
        rst_out_n = 1'b1;
        short = 3'b000;
        supply_mv = 13'h0BB8;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_volt();
        t_enable();
        t_fault();
        t_switch();
        t_backup();
        tally_and_finish();
    end
endmodule
